//--- design/display_write_port.sv
// Two-wire slave write port with the segment pattern memory.
`timescale 1ns/1ps
`default_nettype none

module display_write_port
  import serial_link_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  serial_link_if.device     link,
  input  wire logic         interface_select_pin,
  input  wire logic         address_strap_pin,
  input  wire logic         static_drive,
  input  wire logic [1:0]   own_sub_address,
  input  wire logic [7:0]   pattern_index,
  output logic      [3:0]   pattern_nibble,
  output logic      [3:0]   contrast_level,
  output logic      [3:0]   backplane_order
);

  // ---------------------------------------------------------------
  // Pin synchronisers and line events
  // ---------------------------------------------------------------
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic sel_meta, sel_sync, strap_meta, strap_sync;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
      {sel_meta, sel_sync, strap_meta, strap_sync} <= 4'h0;
    end else begin
      {scl_meta, scl_sync, scl_prev} <= {link.scl, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {link.serial_data_input_pin, sda_meta, sda_sync};
      {sel_meta, sel_sync} <= {interface_select_pin, sel_meta};
      {strap_meta, strap_sync} <= {address_strap_pin, strap_meta};
    end
  end

  wire scl_rise   = scl_sync & ~scl_prev;
  wire scl_fall   = ~scl_sync & scl_prev;
  wire start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  wire stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;
  wire port_on    = ~sel_sync;

  // ---------------------------------------------------------------
  // Byte assembly and decode
  // ---------------------------------------------------------------
  device_state_type state, next_state;
  logic [3:0] bit_count;
  logic [7:0] shift;
  logic       single_byte, next_single_byte;
  logic       ack_flag, next_ack_flag;
  logic       drive_low;
  logic [1:0] bank_select;
  logic [7:0] write_addr;
  logic [3:0] pattern_mem [0:PATTERN_DEPTH-1];

  wire [7:0] next_shift = {shift[6:0], sda_sync};
  wire       data_bit   = scl_rise && (bit_count <= LAST_DATA_BIT);
  wire       byte_done  = scl_rise && (bit_count == LAST_DATA_BIT);
  wire       sub_ok     = (bank_select == own_sub_address);
  wire [3:0] opcode     = next_shift[7:4];
  wire [3:0] operand    = next_shift[3:0];
  wire       is_guarded = (opcode == OP_CONTRAST) || (opcode == OP_BACKPLANE);

  wire [6:0] addr_a     = strap_sync ? ADDR_A_STRAP1 : ADDR_A_STRAP0;
  wire [6:0] addr_b     = strap_sync ? ADDR_B_STRAP1 : ADDR_B_STRAP0;
  wire       addr_match = ((next_shift[7:1] == addr_a) || (next_shift[7:1] == addr_b)) &&
                          !next_shift[0];

  wire cmd_taken  = byte_done && (state == st_command) && (!is_guarded || sub_ok);
  wire nibble_end = data_bit && ((bit_count == LAST_UPPER_BIT) ||
                                 (bit_count == LAST_DATA_BIT));
  wire nibble_wr  = (state == st_data) && nibble_end && sub_ok;
  wire [3:0] nibble = {next_shift[0], next_shift[1], next_shift[2], next_shift[3]};

  wire [7:0] last_addr = static_drive ? LAST_ADDR_STAT : LAST_ADDR_QUAD;
  wire [7:0] addr_inc  = (write_addr == last_addr) ? 8'h00 : write_addr + 8'h01;

  always_comb begin
    next_state       = state;
    next_single_byte = single_byte;
    next_ack_flag    = ack_flag;
    if (byte_done) begin
      case (state)
        st_address: begin
          next_ack_flag = addr_match;
          next_state    = addr_match ? st_control : st_ignore;
        end
        st_control: begin
          next_ack_flag    = 1'b1;
          next_state       = next_shift[PAYLOAD_BIT] ? st_data : st_command;
          next_single_byte = next_shift[MORE_BYTES_BIT] & ~next_shift[PAYLOAD_BIT];
        end
        st_command: begin
          next_ack_flag = !is_guarded || sub_ok;
          next_state    = single_byte ? st_control : st_command;
        end
        st_data: begin
          next_ack_flag = sub_ok;
          next_state    = st_data;
        end
        default: begin
          next_ack_flag = 1'b0;
          next_state    = state;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Transfer state and acknowledge timing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= st_idle;
      bit_count   <= 4'h0;
      shift       <= 8'h00;
      single_byte <= 1'b0;
      ack_flag    <= 1'b0;
      drive_low   <= 1'b0;
    end else if (!port_on || stop_seen) begin
      state     <= st_idle;
      bit_count <= 4'h0;
      drive_low <= 1'b0;
    end else if (start_seen) begin
      state       <= st_address;
      bit_count   <= 4'h0;
      single_byte <= 1'b0;
      drive_low   <= 1'b0;
    end else begin
      state       <= next_state;
      single_byte <= next_single_byte;
      ack_flag    <= next_ack_flag;
      if (data_bit) begin
        shift     <= next_shift;
        bit_count <= bit_count + 4'h1;
      end else if (scl_rise && bit_count == ACK_SLOT) begin
        bit_count <= ACK_RELEASE;
      end
      // low from eighth to ninth fall
      if (scl_fall && bit_count == ACK_SLOT) begin
        drive_low <= ack_flag;
      end else if (scl_fall && bit_count == ACK_RELEASE) begin
        drive_low <= 1'b0;
        bit_count <= 4'h0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.serial_data_open_drain_oe_n <= 1'b1;
      link.serial_data_open_drain_out  <= 1'b0;
    end else begin
      link.serial_data_open_drain_oe_n <= ~drive_low;
      link.serial_data_open_drain_out  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Commands and pattern memory
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_select     <= 2'h0;
      write_addr      <= 8'h00;
      contrast_level  <= 4'h0;
      backplane_order <= 4'h0;
    end else if (port_on && !start_seen && !stop_seen) begin
      if (cmd_taken) begin
        case (opcode)
          OP_ADDRESS_HIGH: write_addr[7:4] <= operand;
          OP_ADDRESS_LOW:  write_addr[3:0] <= operand;
          OP_BANK_ADDRESS: bank_select     <= operand[1:0];
          OP_CONTRAST:     contrast_level  <= operand;
          OP_BACKPLANE:    backplane_order <= operand;
          default:         bank_select     <= bank_select;
        endcase
      end else if (nibble_wr) begin
        write_addr <= addr_inc;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PATTERN_DEPTH; i++) begin
        pattern_mem[i] <= 4'h0;
      end
      pattern_nibble <= 4'h0;
    end else begin
      if (port_on && !start_seen && !stop_seen && nibble_wr &&
          (int'(write_addr) < PATTERN_DEPTH)) begin
        pattern_mem[write_addr] <= nibble;
      end
      pattern_nibble <= (int'(pattern_index) < PATTERN_DEPTH) ?
                        pattern_mem[pattern_index] : 4'h0;
    end
  end

endmodule
`default_nettype wire

//--- common/serial_link_pkg.sv
// Shared constants and types for the two-wire display write link.
package serial_link_pkg;

  // ---------------------------------------------------------------
  // Clock and link timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 8;
  localparam int SCL_LOW_NS         = 1300;
  localparam int SCL_CYCLE_NS       = 2500;
  localparam int DATA_HOLD_NS       = 100;
  localparam int START_SETUP_NS     = 600;
  localparam int START_HOLD_NS      = 600;
  localparam int STOP_SETUP_NS      = 600;
  localparam int BUS_FREE_NS        = 1300;
  localparam int SCL_LOW_CYCLES     = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HIGH_CYCLES    =
    (SCL_CYCLE_NS - SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_HOLD_CYCLES   = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_SETUP_CYCLES = (START_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HOLD_CYCLES  = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_SETUP_CYCLES  = (STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FREE_CYCLES    = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Byte framing and addressing
  // ---------------------------------------------------------------
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0] LAST_UPPER_BIT = 4'h3;
  localparam logic [3:0] ACK_SLOT       = 4'h8;
  localparam logic [3:0] ACK_RELEASE    = 4'h9;
  localparam logic [6:0] ADDR_A_STRAP0  = 7'h3e;
  localparam logic [6:0] ADDR_B_STRAP0  = 7'h38;
  localparam logic [6:0] ADDR_A_STRAP1  = 7'h3f;
  localparam logic [6:0] ADDR_B_STRAP1  = 7'h39;
  localparam int         MORE_BYTES_BIT = 7;
  localparam int         PAYLOAD_BIT    = 6;

  // ---------------------------------------------------------------
  // Command opcodes (upper nibble) and pattern memory
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_ADDRESS_HIGH = 4'hb;
  localparam logic [3:0] OP_ADDRESS_LOW  = 4'hc;
  localparam logic [3:0] OP_BANK_ADDRESS = 4'hd;
  localparam logic [3:0] OP_CONTRAST     = 4'he;
  localparam logic [3:0] OP_BACKPLANE    = 4'hf;
  localparam int         PATTERN_DEPTH   = 160;
  localparam logic [7:0] LAST_ADDR_QUAD  = 8'h9f;
  localparam logic [7:0] LAST_ADDR_STAT  = 8'h27;

  // ---------------------------------------------------------------
  // Host register port
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_COMMAND = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [1:0] OPC_BYTE    = 2'h0;
  localparam logic [1:0] OPC_START   = 2'h1;
  localparam logic [1:0] OPC_STOP    = 2'h2;

  typedef enum logic [2:0] {
    st_idle, st_address, st_control, st_command, st_data, st_ignore
  } device_state_type;

  typedef enum logic [3:0] {
    h_idle, h_start_release, h_start_high, h_start_hold,
    h_bit_low, h_bit_high, h_stop_low, h_stop_high, h_stop_free
  } host_state_type;

endpackage

//--- common/serial_link_if.sv
// Two-wire link between host and display port, with the open-drain data line resolved.
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic serial_data_open_drain_out;
  logic serial_data_open_drain_oe_n;
  wire  serial_data_input_pin;

  // Pull-up wins unless a party enables its low drive.
  assign serial_data_input_pin = (host_sda_oe_n | host_sda_out) &
                                 (serial_data_open_drain_oe_n | serial_data_open_drain_out);

  modport device (
    input  scl,
    input  serial_data_input_pin,
    output serial_data_open_drain_out,
    output serial_data_open_drain_oe_n
  );

  modport host (
    output scl,
    output host_sda_out,
    output host_sda_oe_n,
    input  serial_data_input_pin
  );
endinterface
`default_nettype wire

//--- design/serial_bus_master.sv
// Two-wire bus master driven by a small command and status register port.
`timescale 1ns/1ps
`default_nettype none
module serial_bus_master
  import serial_link_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  serial_link_if.host       link,
  input  wire logic [3:0]   reg_address,
  input  wire logic [15:0]  reg_write_data,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output logic      [15:0]  reg_read_data
);

  // ---------------------------------------------------------------
  // Register decode and line sampling
  // ---------------------------------------------------------------
  host_state_type state;
  logic [15:0] timer;
  logic [3:0]  bit_index;
  logic [7:0]  tx_shift;
  logic        last_ack;
  logic        sda_meta, sda_sync;

  wire busy      = (state != h_idle);
  wire cmd_write = reg_write && (reg_address == REG_COMMAND) && !busy;
  wire [1:0] opc = reg_write_data[9:8];

  logic [15:0] limit;
  always_comb begin
    case (state)
      h_start_release, h_bit_low, h_stop_low: limit = 16'(SCL_LOW_CYCLES);
      h_start_high:                           limit = 16'(START_SETUP_CYCLES);
      h_start_hold:                           limit = 16'(START_HOLD_CYCLES);
      h_bit_high:                             limit = 16'(SCL_HIGH_CYCLES);
      h_stop_high:                            limit = 16'(STOP_SETUP_CYCLES);
      h_stop_free:                            limit = 16'(BUS_FREE_CYCLES);
      default:                                limit = 16'h0001;
    endcase
  end
  wire phase_done = (timer == limit - 16'h0001);
  wire hold_done  = (timer == 16'(DATA_HOLD_CYCLES));
  wire ack_bit    = (bit_index == ACK_SLOT);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sda_meta, sda_sync} <= 2'h3;
    end else begin
      {sda_meta, sda_sync} <= {link.serial_data_input_pin, sda_meta};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_read_data <= 16'h0000;
    end else if (reg_read && reg_address == REG_STATUS) begin
      reg_read_data <= {14'h0000, last_ack, busy};
    end else begin
      reg_read_data <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Line sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state              <= h_idle;
      timer              <= 16'h0000;
      bit_index          <= 4'h0;
      tx_shift           <= 8'h00;
      last_ack           <= 1'b0;
      link.scl           <= 1'b1;
      link.host_sda_out  <= 1'b0;
      link.host_sda_oe_n <= 1'b1;
    end else begin
      timer <= (state == h_idle || phase_done) ? 16'h0000 : timer + 16'h0001;
      case (state)
        h_idle: begin
          if (cmd_write) begin
            case (opc)
              OPC_START: state <= h_start_release;
              OPC_STOP:  state <= h_stop_low;
              default: begin
                tx_shift  <= reg_write_data[7:0];
                bit_index <= 4'h0;
                state     <= h_bit_low;
              end
            endcase
            link.scl <= (opc == OPC_START) ? link.scl : 1'b0;
          end
        end
        h_start_release: begin
          link.scl           <= 1'b0;
          link.host_sda_oe_n <= 1'b1;
          if (phase_done) state <= h_start_high;
        end
        h_start_high: begin
          link.scl <= 1'b1;
          if (phase_done) state <= h_start_hold;
        end
        h_start_hold: begin
          link.host_sda_oe_n <= 1'b0;
          if (phase_done) begin
            link.scl <= 1'b0;
            state    <= h_idle;
          end
        end
        h_bit_low: begin
          link.scl <= 1'b0;
          if (hold_done) begin
            link.host_sda_oe_n <= ack_bit ? 1'b1 : tx_shift[7];
          end
          if (phase_done) state <= h_bit_high;
        end
        h_bit_high: begin
          link.scl <= 1'b1;
          if (phase_done) begin
            link.scl  <= 1'b0;
            tx_shift  <= {tx_shift[6:0], 1'b0};
            bit_index <= bit_index + 4'h1;
            state     <= ack_bit ? h_idle : h_bit_low;
            if (ack_bit) last_ack <= ~sda_sync;
          end
        end
        h_stop_low: begin
          link.scl <= 1'b0;
          if (hold_done) link.host_sda_oe_n <= 1'b0;
          if (phase_done) state <= h_stop_high;
        end
        h_stop_high: begin
          link.scl <= 1'b1;
          if (phase_done) state <= h_stop_free;
        end
        h_stop_free: begin
          link.host_sda_oe_n <= 1'b1;
          if (phase_done) state <= h_idle;
        end
        default: state <= h_idle;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- test/display_write_port_asserts.sv
// Concurrent checks on the two-wire link between bus master and display port.
`timescale 1ns/1ps
`default_nettype none
module display_write_port_asserts
  import serial_link_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic serial_data_open_drain_out,
  input wire logic serial_data_open_drain_oe_n,
  input wire logic serial_data_input_pin
);
  // ------------------------------------------------------------
  // Bit and acknowledge bookkeeping
  // ------------------------------------------------------------
  localparam int ACK_MIN = SCL_LOW_CYCLES + SCL_HIGH_CYCLES - 8;
  localparam int ACK_MAX = SCL_LOW_CYCLES + SCL_HIGH_CYCLES + 8;
  logic       sda;
  logic       drive_n;
  logic       sda_q;
  logic       scl_q;
  logic [8:0] ack_len;
  logic [3:0] rises;
  assign sda     = serial_data_input_pin;
  assign drive_n = serial_data_open_drain_oe_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Counts clock rises since START; the ninth rise closes a byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_q   <= 1'b1;
      scl_q   <= 1'b1;
      ack_len <= 9'h000;
      rises   <= 4'h0;
    end else begin
      sda_q   <= sda;
      scl_q   <= scl;
      ack_len <= drive_n ? 9'h000 : ack_len + 9'h001;
      if (sda_q && !sda && scl) begin
        rises <= 4'h0;
      end else if (!scl_q && scl) begin
        rises <= (rises == ACK_SLOT) ? 4'h0 : rises + 4'h1;
      end
    end
  end

  sequence start_cond;
    $fell(sda) && scl;
  endsequence
  sequence stop_cond;
    $rose(sda) && scl;
  endsequence
  sequence ack_high;
    $rose(scl) && !drive_n;
  endsequence

  a_drain_never_high: assert property (!drive_n |-> !serial_data_open_drain_out && !sda)
    else $error("display port drove the line high");
  a_host_low_only: assert property (!host_sda_oe_n |-> !host_sda_out)
    else $error("master drove the line high");
  a_ack_after_byte: assert property ($fell(drive_n) |-> !scl && rises == ACK_SLOT)
    else $error("acknowledge began outside its slot");
  a_ack_ends_low: assert property ($rose(drive_n) |-> !scl && rises == 4'h0)
    else $error("acknowledge ended away from the ninth fall");
  a_ack_width_ok: assert property ($rose(drive_n) |-> ack_len inside {[ACK_MIN:ACK_MAX]})
    else $error("acknowledge drive length wrong");
  a_ack_spans_high: assert property (ack_high |-> (!drive_n)[*8])
    else $error("acknowledge dropped while clock high");
  a_host_hears_ack: assert property (ack_high |-> host_sda_oe_n)
    else $error("master drove the line in the acknowledge slot");
  a_start_hold: assert property (start_cond |-> scl[*8])
    else $error("clock fell too soon after start");
  a_stop_free: assert property (stop_cond |=> sda[*8])
    else $error("line not free after stop");
endmodule
`default_nettype wire

//--- test/test_two_wire_display_write_port.sv
// Self-checking bench: bus master and display port joined over the link.
`timescale 1ns/1ps
`default_nettype none
module test_two_wire_display_write_port
  import serial_link_pkg::*;
();
  logic        clk                  = 1'b0;
  logic        rst                  = 1'b1;
  logic [3:0]  reg_address          = 4'h0;
  logic [15:0] reg_write_data       = 16'h0000;
  logic        reg_write            = 1'b0;
  logic        reg_read             = 1'b0;
  logic [15:0] reg_read_data;
  logic        interface_select_pin = 1'b0;
  logic        address_strap_pin    = 1'b0;
  logic        static_drive         = 1'b0;
  logic [1:0]  own_sub_address      = 2'h1;
  logic [7:0]  pattern_index        = 8'h00;
  logic [3:0]  pattern_nibble;
  logic [3:0]  contrast_level;
  logic [3:0]  backplane_order;
  logic [15:0] seed                 = 16'h67c3;
  int          n_mismatch           = 0;
  int          checked              = 0;
  int          mem [160];
  int          written [$];
  int          mst, co, bank, addr, ctr, bpo;

  serial_link_if link ();
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  display_write_port u_display_write_port (
    .clk(clk), .rst(rst), .link(link.device),
    .interface_select_pin(interface_select_pin),
    .address_strap_pin(address_strap_pin),
    .static_drive(static_drive),
    .own_sub_address(own_sub_address),
    .pattern_index(pattern_index),
    .pattern_nibble(pattern_nibble),
    .contrast_level(contrast_level),
    .backplane_order(backplane_order)
  );
  serial_bus_master u_serial_bus_master (
    .clk(clk), .rst(rst), .link(link.host),
    .reg_address(reg_address), .reg_write_data(reg_write_data),
    .reg_write(reg_write), .reg_read(reg_read), .reg_read_data(reg_read_data)
  );
  display_write_port_asserts u_display_write_port_asserts (
    .clk(clk), .rst(rst), .scl(link.scl),
    .host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n),
    .serial_data_open_drain_out(link.serial_data_open_drain_out),
    .serial_data_open_drain_oe_n(link.serial_data_open_drain_oe_n),
    .serial_data_input_pin(link.serial_data_input_pin)
  );

  // ------------------------------------------------------------
  // Checking, bus tasks and reference model
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  task automatic reg_rd(output logic [15:0] d);
    @(posedge clk);
    reg_address <= REG_STATUS;
    reg_read    <= 1'b1;
    @(posedge clk);
    reg_read    <= 1'b0;
    #1 d = reg_read_data;
  endtask

  // Issues one master command and polls busy; returns the acknowledge flag.
  task automatic op(input logic [1:0] o, input logic [7:0] b, output logic a);
    logic [15:0] s;
    @(posedge clk);
    reg_address    <= REG_COMMAND;
    reg_write_data <= {6'h00, o, b};
    reg_write      <= 1'b1;
    @(posedge clk);
    reg_write      <= 1'b0;
    s = 16'h0001;
    for (int n = 0; n < 4000 && s[0] !== 1'b0; n++) reg_rd(s);
    if (s[0] !== 1'b0) begin
      check("busy", s, 16'h0000);
      tally_and_finish();
    end
    a = s[1];
  endtask

  task automatic frame(input logic [1:0] o);
    logic a;
    op(o, 8'h00, a);
    mst = (o == OPC_START) ? 1 : 0;
  endtask

  task automatic put(input logic [3:0] n);
    mem[addr] = {n[0], n[1], n[2], n[3]};
    written.push_back(addr);
    addr = (addr == (static_drive ? LAST_ADDR_STAT : LAST_ADDR_QUAD)) ? 0 : addr + 1;
  endtask

  task automatic send(input logic [7:0] b);
    logic a;
    logic e;
    op(OPC_BYTE, b, a);
    e = 1'b1;
    case (mst)
      1: e = b[7:4] == 4'h7 && b[3] == b[2] && b[1] == address_strap_pin && !b[0]
             && !interface_select_pin;
      2: begin
        co  = b[MORE_BYTES_BIT];
        mst = b[PAYLOAD_BIT] ? 4 : 3;
      end
      3: begin
        case (b[7:4])
          OP_ADDRESS_HIGH: addr = b[3:0] * 16 + addr % 16;
          OP_ADDRESS_LOW:  addr = addr / 16 * 16 + b[3:0];
          OP_BANK_ADDRESS: bank = b[1:0];
          default:         e = bank == own_sub_address || b[7:4] < OP_CONTRAST;
        endcase
        if (e && b[7:4] == OP_CONTRAST) ctr = b[3:0];
        if (e && b[7:4] == OP_BACKPLANE) bpo = b[3:0];
        if (co) mst = 2;
      end
      4: begin
        e = bank == own_sub_address;
        if (e) put(b[7:4]);
        if (e) put(b[3:0]);
      end
      default: e = 1'b0;
    endcase
    if (mst == 1) mst = e ? 2 : 5;
    check("ack", a, e);
    check("contrast", contrast_level, ctr[3:0]);
    check("backplane", backplane_order, bpo[3:0]);
  endtask

  task automatic pins(input logic sel, input logic strap, input logic stat);
    @(posedge clk);
    interface_select_pin <= sel;
    address_strap_pin    <= strap;
    static_drive         <= stat;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pins(1'b0, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    frame(OPC_START);
    send(8'h7c);
    send(8'h7e);
    frame(OPC_START);
    send(8'h7e);
    send(8'h00);
    send(8'hd1);
    send(8'hb9);
    send(8'hcf);
    send(8'he5);
    send(8'hf3);
    send(8'h40);
    send(8'he7);
    frame(OPC_STOP);
    pins(1'b0, 1'b0, 1'b0);
    frame(OPC_START);
    send(8'h70);
    send(8'h40);
    send(rnd());
    send(8'h80);
    frame(OPC_STOP);
    pins(1'b0, 1'b0, 1'b1);
    frame(OPC_START);
    send(8'h7c);
    send(8'h80);
    send(8'hb2);
    send(8'h80);
    send(8'hc7);
    send(8'h40);
    send(rnd());
    frame(OPC_STOP);
    pins(1'b0, 1'b0, 1'b0);
    frame(OPC_START);
    send(8'h7c);
    send(8'h80);
    send(8'hd2);
    send(8'h80);
    send(8'he9);
    send(8'h40);
    send(rnd());
    frame(OPC_STOP);
    pins(1'b1, 1'b0, 1'b0);
    frame(OPC_START);
    send(8'h7c);
    frame(OPC_STOP);
    foreach (written[i]) begin
      @(posedge clk);
      pattern_index <= 8'(written[i]);
      @(posedge clk);
      #1 check("pattern", pattern_nibble, 16'(mem[written[i]]));
    end
    @(posedge clk);
    pattern_index <= 8'ha0;
    @(posedge clk);
    #1 check("pattern_end", pattern_nibble, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
